// ### pkg/cdi_reg_map.svh
// register map, field positions, reset values and timing counts of the
// input module configuration and status word
// assumes a 10 MHz system clock and a word-addressed register port
`ifndef CDI_REG_MAP_SVH
`define CDI_REG_MAP_SVH

`define CDI_ADDR_W 5
`define CDI_DATA_W 16
`define CDI_ADDR_POINTS 5'h00
`define CDI_ADDR_CFG_STS 5'h0D
`define CDI_ADDR_IRQ_STS 5'h0E
`define CDI_ADDR_IRQ_MASK 5'h0F

`define CDI_BIT_CONFIGURE 0
`define CDI_BIT_FORCE 1
`define CDI_BIT_FUSE_EN 6
`define CDI_BIT_FUSE 7
`define CDI_STS_ONES 16'hF83C
`define CDI_CFG_RESET 1'b0
`define CDI_UNMAPPED 16'h0000

`define CDI_IRQ_W 4
`define CDI_IRQ_ATTN 0
`define CDI_IRQ_FUSE 1
`define CDI_IRQ_WDOG 2
`define CDI_IRQ_PT_ATTN 3
`define CDI_IRQ_RESET 4'h0

`define CDI_CLK_HZ 10000000
`define CDI_WDOG_TIME_MS 100
`define CDI_WDOG_CYCLES (`CDI_WDOG_TIME_MS * (`CDI_CLK_HZ / 1000))

`endif

// ### pkg/cdi_pkg.sv
// types shared by the input module configuration block
// assumes the constants of cdi_reg_map.svh
package cdi_pkg;
  typedef logic [15:0] cdi_word_t;
  typedef logic [4:0] cdi_addr_t;
  typedef enum logic [1:0] {
    CDI_UNCONF,
    CDI_FORCED,
    CDI_CONF
  } cdi_mode_t;
endpackage : cdi_pkg

// ### pkg/cdi_wdog_if.sv
// carrier between the register block and its communication watchdog
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cdi_wdog_if;
  logic kick;
  logic expired;
  modport ctrl (output kick, input expired);
  modport tmr (input kick, output expired);
endinterface : cdi_wdog_if

// ### rtl/cdi_rst_sync.sv
// two-stage release of the asynchronous active-low reset
// assumes the raw reset may drop at any time
`timescale 1ns/1ps
module cdi_rst_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic rst_b_out
);
  logic meta_q;

  // assert at once, release after two edges
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= 1'b0;
      rst_b_out <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      rst_b_out <= meta_q;
    end
  end
endmodule : cdi_rst_sync

// ### rtl/cdi_wdog.sv
// communication watchdog: expires when no kick arrives for CYCLES clocks
// assumes a synchronised active-low reset
`timescale 1ns/1ps
module cdi_wdog #(
  parameter int unsigned CYCLES = 1000000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  cdi_wdog_if.tmr wd
);
  logic [31:0] cnt_q;

  // count idle cycles, restart on every kick
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 32'h0000_0000;
    end else if (wd.kick) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q < CYCLES[31:0]) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // expiry holds until the controller talks again
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wd.expired <= 1'b0;
    end else if (wd.kick) begin
      wd.expired <= 1'b0;
    end else if (cnt_q >= CYCLES[31:0] - 32'h0000_0001) begin
      wd.expired <= 1'b1;
    end
  end
endmodule : cdi_wdog

// ### rtl/cdi_cfg_sts.sv
// configuration and status word of the 16-channel digital input module,
// plus point data, event flags, mask, fault lamps and watchdog
// assumes a synchronous word-addressed register port with one-cycle
// strobes and read data returned in the following cycle
`timescale 1ns/1ps
`include "cdi_reg_map.svh"
module cdi_cfg_sts #(
  parameter int unsigned WDOG_CYCLES = `CDI_WDOG_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [`CDI_ADDR_W-1:0] ADDR_IN,
  input wire logic [`CDI_DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [`CDI_DATA_W-1:0] POINT_IN,
  input wire logic FUSE_BLOWN_IN,
  input wire logic AUX_OK_IN,
  output logic [`CDI_DATA_W-1:0] RDATA_OUT,
  output logic ATTN_OUT,
  output logic IRQ_OUT,
  output logic CONFIGURED_OUT,
  output logic LED_INT_FAULT_OUT,
  output logic LED_EXT_FAULT_OUT
);

  // synchronised reset used by everything below
  logic rst_b;

  // stored configuration bits; all others are dropped on write
  logic cfg_configure_q;
  logic cfg_force_q;
  logic cfg_fuse_en_q;

  // module mode
  cdi_pkg::cdi_mode_t mode_q;
  cdi_pkg::cdi_mode_t mode_d;

  // fuse detection result
  logic fuse_q;
  logic fuse_d;

  // event flags and mask
  logic [`CDI_IRQ_W-1:0] irq_sts_q;
  logic [`CDI_IRQ_W-1:0] irq_sts_d;
  logic [`CDI_IRQ_W-1:0] irq_mask_q;
  logic [`CDI_IRQ_W-1:0] irq_set;
  logic [`CDI_IRQ_W-1:0] irq_clr;

  // decoded accesses
  logic sel_points;
  logic sel_cfg;
  logic sel_irq_sts;
  logic sel_irq_mask;
  logic wr_cfg;
  logic wr_irq_sts;
  logic wr_irq_mask;
  logic rd_points;
  logic rd_any;

  // composed words
  cdi_pkg::cdi_word_t status_word;
  cdi_pkg::cdi_word_t rdata_d;
  logic attention;
  logic attn_d;
  logic wdog_rise;
  logic wdog_seen_q;

  cdi_wdog_if wd_if ();

  cdi_rst_sync u_rst_sync (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .rst_b_out(rst_b)
  );

  cdi_wdog #(
    .CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(rst_b),
    .wd(wd_if.tmr)
  );

  // any controller access counts as communication
  assign wd_if.kick = WR_IN | RD_IN;

  // address decode
  always_comb begin
    sel_points = 1'b0;
    sel_cfg = 1'b0;
    sel_irq_sts = 1'b0;
    sel_irq_mask = 1'b0;
    if (ADDR_IN == `CDI_ADDR_POINTS) begin
      sel_points = 1'b1;
    end else if (ADDR_IN == `CDI_ADDR_CFG_STS) begin
      sel_cfg = 1'b1;
    end else if (ADDR_IN == `CDI_ADDR_IRQ_STS) begin
      sel_irq_sts = 1'b1;
    end else if (ADDR_IN == `CDI_ADDR_IRQ_MASK) begin
      sel_irq_mask = 1'b1;
    end
  end

  // qualified strobes
  assign wr_cfg = WR_IN & sel_cfg;
  assign wr_irq_sts = WR_IN & sel_irq_sts;
  assign wr_irq_mask = WR_IN & sel_irq_mask;
  assign rd_points = RD_IN & sel_points;
  assign rd_any = RD_IN;

  // configure bit, cleared by reset
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      cfg_configure_q <= `CDI_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_configure_q <= WDATA_IN[`CDI_BIT_CONFIGURE];
    end
  end

  // forced-error bit, cleared by reset
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      cfg_force_q <= `CDI_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_force_q <= WDATA_IN[`CDI_BIT_FORCE];
    end
  end

  // fuse detection enable, cleared by reset
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      cfg_fuse_en_q <= `CDI_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_fuse_en_q <= WDATA_IN[`CDI_BIT_FUSE_EN];
    end
  end

  // mode follows the configuration bits one cycle later
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cdi_pkg::CDI_UNCONF: begin
        if (cfg_configure_q && !cfg_force_q) begin
          mode_d = cdi_pkg::CDI_CONF;
        end else if (cfg_configure_q) begin
          mode_d = cdi_pkg::CDI_FORCED;
        end
      end
      cdi_pkg::CDI_FORCED: begin
        if (!cfg_configure_q) begin
          mode_d = cdi_pkg::CDI_UNCONF;
        end else if (!cfg_force_q) begin
          mode_d = cdi_pkg::CDI_CONF;
        end
      end
      cdi_pkg::CDI_CONF: begin
        if (!cfg_configure_q) begin
          mode_d = cdi_pkg::CDI_UNCONF;
        end else if (cfg_force_q) begin
          mode_d = cdi_pkg::CDI_FORCED;
        end
      end
      default: begin
        mode_d = cdi_pkg::CDI_UNCONF;
      end
    endcase
  end

  // mode register
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= cdi_pkg::CDI_UNCONF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // attention is pending in every mode but plain configured
  assign attention = (mode_q != cdi_pkg::CDI_CONF);

  // blown fuse only counts while detection is enabled
  assign fuse_d = cfg_fuse_en_q & (FUSE_BLOWN_IN | ~AUX_OK_IN);

  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      fuse_q <= 1'b0;
    end else begin
      fuse_q <= fuse_d;
    end
  end

  // status word: fixed ones, reserved zeros, live fields
  always_comb begin
    status_word = `CDI_STS_ONES;
    status_word[`CDI_BIT_CONFIGURE] = cfg_configure_q;
    status_word[`CDI_BIT_FORCE] = cfg_force_q;
    status_word[`CDI_BIT_FUSE_EN] = cfg_fuse_en_q;
    status_word[`CDI_BIT_FUSE] = fuse_q;
  end

  // read mux; the config address returns status, never the written word
  always_comb begin
    rdata_d = `CDI_UNMAPPED;
    if (sel_points) begin
      rdata_d = POINT_IN;
    end else if (sel_cfg) begin
      rdata_d = status_word;
    end else if (sel_irq_sts) begin
      rdata_d[`CDI_IRQ_W-1:0] = irq_sts_q;
    end else if (sel_irq_mask) begin
      rdata_d[`CDI_IRQ_W-1:0] = irq_mask_q;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      RDATA_OUT <= `CDI_UNMAPPED;
    end else if (rd_any) begin
      RDATA_OUT <= rdata_d;
    end else begin
      RDATA_OUT <= `CDI_UNMAPPED;
    end
  end

  // attention beside read data: unconfigured point reads, forced reads
  always_comb begin
    attn_d = 1'b0;
    if (rd_points && mode_q == cdi_pkg::CDI_UNCONF) begin
      attn_d = 1'b1;
    end else if (rd_any && mode_q == cdi_pkg::CDI_FORCED) begin
      attn_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      ATTN_OUT <= 1'b0;
    end else begin
      ATTN_OUT <= attn_d;
    end
  end

  // watchdog expiry edge for the event flags
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      wdog_seen_q <= 1'b0;
    end else begin
      wdog_seen_q <= wd_if.expired;
    end
  end

  assign wdog_rise = wd_if.expired & ~wdog_seen_q;

  // event sources
  always_comb begin
    irq_set = `CDI_IRQ_RESET;
    irq_set[`CDI_IRQ_ATTN] = (mode_q == cdi_pkg::CDI_CONF) &&
                             (mode_d != cdi_pkg::CDI_CONF);
    irq_set[`CDI_IRQ_FUSE] = fuse_d & ~fuse_q;
    irq_set[`CDI_IRQ_WDOG] = wdog_rise;
    irq_set[`CDI_IRQ_PT_ATTN] = attn_d;
  end

  // write one to clear; a set in the same cycle wins
  always_comb begin
    irq_clr = `CDI_IRQ_RESET;
    if (wr_irq_sts) begin
      irq_clr = WDATA_IN[`CDI_IRQ_W-1:0];
    end
    irq_sts_d = (irq_sts_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      irq_sts_q <= `CDI_IRQ_RESET;
    end else begin
      irq_sts_q <= irq_sts_d;
    end
  end

  // interrupt mask, one enables the matching flag
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= `CDI_IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_q <= WDATA_IN[`CDI_IRQ_W-1:0];
    end
  end

  // level interrupt from unmasked flags
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_sts_d & irq_mask_q);
    end
  end

  // configured indication
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      CONFIGURED_OUT <= 1'b0;
    end else begin
      CONFIGURED_OUT <= cfg_configure_q;
    end
  end

  // internal fault lamp: forced error or lost communication
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      LED_INT_FAULT_OUT <= 1'b0;
    end else begin
      LED_INT_FAULT_OUT <= cfg_force_q | wd_if.expired;
    end
  end

  // external fault lamp follows the blown fuse bit
  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      LED_EXT_FAULT_OUT <= 1'b0;
    end else begin
      LED_EXT_FAULT_OUT <= fuse_d;
    end
  end

endmodule : cdi_cfg_sts

// ### dv/cdi_cfg_sts_props.sv
// checker for the configuration and status word, on the top ports only
// assumes it is bound into cdi_cfg_sts
`timescale 1ns/1ps
module cdi_cfg_sts_props #(
  parameter int unsigned WDOG_CYCLES = 20
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] POINT_IN,
  input wire logic FUSE_BLOWN_IN,
  input wire logic AUX_OK_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic ATTN_OUT,
  input wire logic IRQ_OUT,
  input wire logic CONFIGURED_OUT,
  input wire logic LED_INT_FAULT_OUT,
  input wire logic LED_EXT_FAULT_OUT
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // read strobe at the status word
  sequence s_rd13;
    RD_IN && ADDR_IN == 5'h0D;
  endsequence
  // answer of a status read with no write in the cycles before it
  sequence s_ans13;
    $past(RD_IN) && $past(ADDR_IN) == 5'h0D && !$past(WR_IN, 2) && !$past(WR_IN, 3)
      && !$past(WR_IN, 4);
  endsequence
  chk_fixed_ones: assert property (s_rd13 |=> RDATA_OUT[15:11] == 5'h1F && RDATA_OUT[5:2] == 4'hF)
    else $error("fixed status bits low");
  chk_rsvd_low: assert property (s_rd13 |=> RDATA_OUT[10:8] == 3'h0)
    else $error("reserved status bits set");
  chk_idle_quiet: assert property (!RD_IN |=> RDATA_OUT == 16'h0000 && !ATTN_OUT)
    else $error("read data without read");
  chk_unconf_attn: assert property (RD_IN && ADDR_IN == 5'h00 && !CONFIGURED_OUT
    && !$past(WR_IN) && !$past(WR_IN, 2) |=> ATTN_OUT)
    else $error("no attention on unconfigured point read");
  chk_force_attn: assert property (s_ans13 ##0 RDATA_OUT[1:0] == 2'h3 |-> ATTN_OUT)
    else $error("no attention with forced error");
  chk_conf_quiet: assert property (s_ans13 ##0 RDATA_OUT[1:0] == 2'h1 |-> !ATTN_OUT)
    else $error("attention while configured");
  chk_fuse_gate: assert property (s_ans13 ##0 RDATA_OUT[7] |-> RDATA_OUT[6])
    else $error("blown fuse without enable");
  chk_int_lamp: assert property (s_ans13 ##0 RDATA_OUT[1] |-> LED_INT_FAULT_OUT)
    else $error("internal lamp dark with forced error");
endmodule : cdi_cfg_sts_props

bind cdi_cfg_sts cdi_cfg_sts_props #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .POINT_IN(POINT_IN), .FUSE_BLOWN_IN(FUSE_BLOWN_IN),
  .AUX_OK_IN(AUX_OK_IN), .RDATA_OUT(RDATA_OUT), .ATTN_OUT(ATTN_OUT), .IRQ_OUT(IRQ_OUT),
  .CONFIGURED_OUT(CONFIGURED_OUT), .LED_INT_FAULT_OUT(LED_INT_FAULT_OUT),
  .LED_EXT_FAULT_OUT(LED_EXT_FAULT_OUT));

// ### dv/cdi_ctrl_model.sv
// controller model driving the word-addressed register port
// assumes tasks are entered right after a rising clock edge
`timescale 1ns/1ps
module cdi_ctrl_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  input wire logic attn_in,
  output logic [4:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // port idles with no strobe
  initial begin
    addr_out = 5'h00;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write; data lines scrambled once released
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : wr
  // one-cycle read; answer taken at the next edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic at);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
    at = attn_in;
  endtask : rd
endmodule : cdi_ctrl_model

// ### dv/test_input_module_config_status_reg.sv
// self-checking bench for the configuration and status word
// assumes the controller model and the bound checker
`timescale 1ns/1ps
module test_input_module_config_status_reg;
  localparam int unsigned WD = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] point = 16'h0000;
  logic fuse = 1'b0;
  logic aux = 1'b1;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic attn, irq, conf, led_i, led_e;
  logic [15:0] d;
  logic [15:0] w;
  logic at;
  integer seed = 96;
  int num_errors = 0;
  int checks_done = 0;
  // clock of 100 ns period
  always #50 clk = ~clk;
  cdi_cfg_sts #(.WDOG_CYCLES(WD)) dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .POINT_IN(point), .FUSE_BLOWN_IN(fuse),
    .AUX_OK_IN(aux), .RDATA_OUT(rdata), .ATTN_OUT(attn), .IRQ_OUT(irq),
    .CONFIGURED_OUT(conf), .LED_INT_FAULT_OUT(led_i), .LED_EXT_FAULT_OUT(led_e));
  cdi_ctrl_model ctl (.clk_in(clk), .rdata_in(rdata), .attn_in(attn), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // expected status from configuration and fuse inputs
  function automatic logic [15:0] exp_sts(input logic [15:0] c, input logic f, input logic a);
    exp_sts = 16'hF83C | {8'h00, c[6] & (f | ~a), c[6], 4'h0, c[1:0]};
  endfunction : exp_sts
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // hold reset 20 cycles, then wait out the synchroniser
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // main sequence
  initial begin
    do_reset();
    ctl.rd(5'h0D, d, at);
    chk("reset status", 16'hF83C, d);
    chk("reset attn", 16'h0000, at);
    ctl.rd(5'h00, d, at);
    chk("unconf point attn", 16'h0001, at);
    $display("test reset state done");
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'hFFBC : 16'($random(seed));
      fuse <= 1'($random(seed));
      aux <= 1'($random(seed));
      point <= 16'($random(seed));
      ctl.wr(5'h0D, w);
      repeat (3) @(posedge clk);
      ctl.rd(5'h0D, d, at);
      chk("status", exp_sts(w, fuse, aux), d);
      chk("status attn", {15'h0000, w[0] & w[1]}, at);
      chk("lamps", {14'h0000, w[1], w[6] & (fuse | ~aux)}, {14'h0000, led_i, led_e});
      chk("configured", {15'h0000, w[0]}, {15'h0000, conf});
      ctl.rd(5'h00, d, at);
      chk("point attn", {15'h0000, ~w[0] | w[1]}, at);
      if (w[0] & ~w[1]) begin
        chk("point data", point, d);
      end
    end
    $display("test random words done");
    ctl.wr(5'h0D, 16'h0000);
    repeat (3) @(posedge clk);
    ctl.wr(5'h0D, 16'h0001);
    ctl.rd(5'h0D, d, at);
    chk("status after write", exp_sts(16'h0001, fuse, aux), d);
    chk("old mode attn", 16'h0000, at);
    ctl.rd(5'h1F, d, at);
    chk("unmapped read", 16'h0000, d);
    // one idle edge between writes keeps each strobe a single assignment per step
    ctl.wr(5'h0F, 16'h0000);
    @(posedge clk);
    ctl.wr(5'h0E, 16'h000F);
    @(posedge clk);
    ctl.wr(5'h0D, 16'h0000);
    repeat (3) @(posedge clk);
    chk("masked irq", 16'h0000, irq);
    ctl.wr(5'h0F, 16'h0001);
    repeat (2) @(posedge clk);
    chk("unmasked irq", 16'h0001, irq);
    ctl.rd(5'h0E, d, at);
    chk("event flags", 16'h0001, d);
    ctl.wr(5'h0E, 16'h0001);
    repeat (2) @(posedge clk);
    chk("cleared irq", 16'h0000, irq);
    repeat (WD + 5) @(posedge clk);
    chk("watchdog lamp", 16'h0001, led_i);
    ctl.rd(5'h0E, d, at);
    chk("watchdog flag", 16'h0004, d);
    // single-ended use: detection enabled with a blown fuse present
    fuse <= 1'b1;
    ctl.wr(5'h0D, 16'h0043);
    repeat (2) @(posedge clk);
    ctl.rd(5'h0D, d, at);
    chk("fuse status", exp_sts(16'h0043, 1'b1, aux), d);
    chk("fuse lamp", 16'h0001, led_e);
    do_reset();
    ctl.rd(5'h0D, d, at);
    chk("second reset status", 16'hF83C, d);
    $display("test directed cases done");
    give_verdict();
  end
endmodule : test_input_module_config_status_reg
